// ===== logic/sram_pin_control.sv
// Purpose: pin-level control of a flow-through burst SRAM, seen from the memory
// Assumes: strobes, selects, address and data are synchronous to core_clk
// Notes: output enable, sleep and burst-order strap pass a three-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
module sram_pin_control
  import sram_pin_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic chip_select_first_low,
  input wire logic chip_select_mid_high,
  input wire logic chip_select_last_low,
  input wire logic package_is_bga,
  input wire logic cpu_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic lane_write_enable_n,
  input wire logic [LANES-1:0] lane_select_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_interleave_strap,
  input wire logic [DATA_W-1:0] data_pins_in,
  output logic [DATA_W-1:0] data_pins_out,
  output logic [DATA_W-1:0] data_pins_oe,
  input wire logic [LANES-1:0] parity_pins_in,
  output logic [LANES-1:0] parity_pins_out,
  output logic [LANES-1:0] parity_pins_oe
);

  logic [ASYNC_N-1:0] async_raw;
  logic [ASYNC_N-1:0] sync1_q, sync2_q, sync3_q, async_q;
  logic oe_n_s, sleep_s, interleave_s;
  logic load_cpu, load_ctrl, load, chips_on, write_req, wr_en, drive_d;
  logic [LANES-1:0] lane_we;
  logic [ADDR_W-1:0] base_addr_q, cur_addr, next_addr, wr_addr;
  logic [BURST_W-1:0] count_q, count_d, low_bits;
  access_state_type state_q, state_d;
  logic drive_q;
  logic [WORD_W-1:0] rd_word_q, wr_word;
  logic [WORD_W-1:0] mem [DEPTH];

  assign async_raw[OE_IDX] = output_enable_n;
  assign async_raw[SLEEP_IDX] = sleep_request;
  assign async_raw[MODE_IDX] = burst_interleave_strap;

  // A level change is accepted only when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < ASYNC_N; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_q[gi] <= ASYNC_RESET[gi];
          sync2_q[gi] <= ASYNC_RESET[gi];
          sync3_q[gi] <= ASYNC_RESET[gi];
          async_q[gi] <= ASYNC_RESET[gi];
        end else begin
          sync1_q[gi] <= async_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            async_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

  assign oe_n_s = async_q[OE_IDX];
  assign sleep_s = async_q[SLEEP_IDX];
  assign interleave_s = async_q[MODE_IDX];

  // Sleep blocks every new access so the array is left untouched
  assign load_cpu = !cpu_addr_strobe_n && !chip_select_first_low && !sleep_s;
  assign load_ctrl = !ctrl_addr_strobe_n && !load_cpu && !sleep_s;
  assign load = load_cpu || load_ctrl;
  assign chips_on = !chip_select_first_low && chip_select_mid_high
                    && (package_is_bga || !chip_select_last_low);

  // Burst address from the captured start bits and the beat count
  always_comb begin
    low_bits = interleave_s ? (base_addr_q[BURST_W-1:0] ^ count_q)
                            : BURST_W'(base_addr_q[BURST_W-1:0] + count_q);
    cur_addr = {base_addr_q[ADDR_W-1:BURST_W], low_bits};
  end

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    if (load) begin
      // Selects only matter here, never on advanced beats
      if (!chips_on) begin
        state_d = ACC_DESELECTED;
      end else if (state_q == ACC_DESELECTED) begin
        state_d = ACC_FIRST;
      end else begin
        state_d = ACC_ACTIVE;
      end
      count_d = BEAT_ZERO;
    end else if (state_q != ACC_DESELECTED) begin
      state_d = ACC_ACTIVE;
      if (!burst_advance_n && !sleep_s) begin
        count_d = BURST_W'(count_q + BEAT_ONE);
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ACC_DESELECTED;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      base_addr_q <= ADDR_RESET;
      count_q <= BEAT_ZERO;
    end else begin
      if (load) begin
        base_addr_q <= address;
      end
      count_q <= count_d;
    end
  end

  always_comb begin
    next_addr = cur_addr;
    if (load) begin
      next_addr = address;
    end else if (count_d != count_q) begin
      next_addr[BURST_W-1:0] = interleave_s
        ? (base_addr_q[BURST_W-1:0] ^ count_d)
        : BURST_W'(base_addr_q[BURST_W-1:0] + count_d);
    end
  end

  // Write inputs in a processor-strobe cycle write nothing, but still release the bus
  assign write_req = !lane_write_enable_n && (lane_select_n != '1);
  assign wr_en = write_req && !sleep_s && !load_cpu
                 && ((load_ctrl && chips_on) || (!load && state_q != ACC_DESELECTED));
  assign wr_addr = load_ctrl ? address : cur_addr;

  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      assign lane_we[gi] = wr_en && !lane_select_n[gi];
      assign wr_word[gi*LANE_W +: LANE_W] =
        {parity_pins_in[gi], data_pins_in[gi*BYTE_W +: BYTE_W]};
      assign data_pins_out[gi*BYTE_W +: BYTE_W] = rd_word_q[gi*LANE_W +: BYTE_W];
      assign parity_pins_out[gi] = rd_word_q[gi*LANE_W + BYTE_W];
    end
  endgenerate

  // No reset on the array: contents survive reset and sleep alike
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (lane_we[i]) begin
        mem[wr_addr][i*LANE_W +: LANE_W] <= wr_word[i*LANE_W +: LANE_W];
      end
    end
  end

  // Flow-through read: the word for the address in force after this edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_word_q <= WORD_RESET;
    end else begin
      rd_word_q <= mem[next_addr];
    end
  end

  assign drive_d = (state_d == ACC_ACTIVE) && !wr_en;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_q <= 1'h0;
    end else begin
      drive_q <= drive_d;
    end
  end

  // A pending write request releases the bus at once, before its edge
  always_comb begin
    logic en;
    en = drive_q && !oe_n_s && !sleep_s && !(write_req && state_q != ACC_DESELECTED);
    data_pins_oe = {DATA_W{en}};
    parity_pins_oe = {LANES{en}};
  end

  sequence burst_step;
    !load && !sleep_s && state_q != ACC_DESELECTED && !burst_advance_n;
  endsequence
  sequence burst_still;
    !load && state_q != ACC_DESELECTED && burst_advance_n;
  endsequence

  chk_burst_advance: assert property (@(posedge core_clk) disable iff (!reset_n)
    burst_step |=> count_q == BURST_W'($past(count_q) + BEAT_ONE))
    else $error("burst counter did not step");
  chk_burst_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    burst_still |=> $stable(count_q))
    else $error("burst counter moved without advance");
  chk_strobe_capture: assert property (@(posedge core_clk) disable iff (!reset_n)
    load |=> base_addr_q == $past(address) && count_q == BEAT_ZERO)
    else $error("strobe did not capture address");
  chk_strobe_priority: assert property (@(posedge core_clk) disable iff (!reset_n)
    !cpu_addr_strobe_n && !ctrl_addr_strobe_n && !chip_select_first_low |-> !wr_en)
    else $error("controller strobe acted beside processor strobe");
  chk_cpu_gated: assert property (@(posedge core_clk) disable iff (!reset_n)
    chip_select_first_low && ctrl_addr_strobe_n |=> $stable(base_addr_q))
    else $error("processor strobe acted while first select high");
  chk_select_decide: assert property (@(posedge core_clk) disable iff (!reset_n)
    load && !chips_on |=> state_q == ACC_DESELECTED ##0 data_pins_oe == '0)
    else $error("device selected with a select inactive");
  chk_first_undriven: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ACC_DESELECTED ##1 state_q == ACC_FIRST |-> data_pins_oe == '0)
    else $error("pins driven in first clock after deselect");
  chk_oe_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
    data_pins_oe[0] |-> !oe_n_s && !sleep_s && parity_pins_oe[0])
    else $error("pins driven while output enable high");
  chk_write_tristate: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_en |-> data_pins_oe == '0 ##1 data_pins_oe == '0 || write_req)
    else $error("pins driven around write data phase");
  chk_lane_enable: assert property (@(posedge core_clk) disable iff (!reset_n)
    lane_write_enable_n |-> lane_we == '0)
    else $error("lane written without lane write enable");
  chk_burst_order: assert property (@(posedge core_clk) disable iff (!reset_n)
    interleave_s |-> cur_addr[BURST_W-1:0] == (base_addr_q[BURST_W-1:0] ^ count_q))
    else $error("interleaved burst address wrong");
  // The read path predicts the address with its own copy of the burst formula
  chk_read_address: assert property (@(posedge core_clk) disable iff (!reset_n)
    load || !burst_advance_n |=> !$stable(interleave_s) || cur_addr == $past(next_addr))
    else $error("read address differs from burst address");

endmodule
`default_nettype wire

// ===== pkg/sram_pin_pkg.sv
// Purpose: shared constants and types for the burst SRAM control-pin block
// Assumes: one 25 MHz core clock; all synchronous pins launched from that clock
// Notes: four byte lanes, each eight data bits plus one parity bit
package sram_pin_pkg;
  localparam int ADDR_W = 20;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int LANE_W = BYTE_W + 1;
  localparam int DATA_W = LANES * BYTE_W;
  localparam int WORD_W = LANES * LANE_W;
  localparam int BURST_W = 2;
  localparam int SYNC_STAGES = 3;
  localparam int ASYNC_N = 3;
  localparam int OE_IDX = 0;
  localparam int SLEEP_IDX = 1;
  localparam int MODE_IDX = 2;
  localparam logic [BURST_W-1:0] BEAT_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BEAT_ONE = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
  localparam logic [WORD_W-1:0] WORD_RESET = 36'h000000000;
  // Safe idle levels for the async pins while the synchronisers fill
  localparam logic [ASYNC_N-1:0] ASYNC_RESET = 3'h5;

  typedef enum logic [1:0] {
    ACC_DESELECTED,
    ACC_FIRST,
    ACC_ACTIVE
  } access_state_type;
endpackage

// ===== sim/sram_host_model.sv
// Purpose: far-side bus master pad model for the burst SRAM pins
// Assumes: the bench supplies the write word, its drive flag and the sleep level
// Notes: undriven lines show the inverse of their last level, never a held value
`timescale 1ns/1ps
`default_nettype none
module sram_host_model
  import sram_pin_pkg::*;
(
  input wire logic core_clk,
  input wire logic drive_en,
  input wire logic [WORD_W-1:0] drive_word,
  input wire logic sleep_on,
  input wire logic [DATA_W-1:0] data_pins_out,
  input wire logic [DATA_W-1:0] data_pins_oe,
  input wire logic [LANES-1:0] parity_pins_out,
  input wire logic [LANES-1:0] parity_pins_oe,
  output logic [DATA_W-1:0] data_pins_in,
  output logic [LANES-1:0] parity_pins_in,
  output logic sleep_request
);
  logic [WORD_W-1:0] last_q;
  logic [WORD_W-1:0] bus_word;
  wire [WORD_W-1:0] dev_oe = {parity_pins_oe, data_pins_oe};
  wire [WORD_W-1:0] dev_out = {parity_pins_out, data_pins_out};
  // Sleep stays low unless a scenario asks for it
  assign sleep_request = sleep_on;
  always_comb begin
    for (int i = 0; i < WORD_W; i++) begin
      bus_word[i] = dev_oe[i] ? dev_out[i] : (drive_en ? drive_word[i] : ~last_q[i]);
    end
  end
  always_ff @(posedge core_clk) begin
    last_q <= bus_word;
  end
  assign data_pins_in = bus_word[DATA_W-1:0];
  assign parity_pins_in = bus_word[WORD_W-1:DATA_W];
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Purpose: self-checking bench for the burst SRAM pin control block
// Assumes: inputs change by non-blocking assignment at the rising edge
// Notes: outputs are read at the falling edge, half a cycle after the inputs change
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sram_pin_pkg::*;
;
  localparam logic [WORD_W-1:0] ONES = 36'hF_FFFF_FFFF;
  logic core_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [ADDR_W-1:0] address = 20'h0;
  logic chip_select_first_low = 1'h0;
  logic chip_select_mid_high = 1'h1;
  logic chip_select_last_low = 1'h0;
  logic package_is_bga = 1'h0;
  logic cpu_addr_strobe_n = 1'h1;
  logic ctrl_addr_strobe_n = 1'h1;
  logic burst_advance_n = 1'h1;
  logic lane_write_enable_n = 1'h1;
  logic [LANES-1:0] lane_select_n = 4'hF;
  logic output_enable_n = 1'h0;
  logic burst_interleave_strap = 1'h1;
  logic sleep_on = 1'h0;
  logic drive_en = 1'h0;
  logic [WORD_W-1:0] drive_word = 36'h0;
  logic sleep_request;
  logic [DATA_W-1:0] data_pins_in, data_pins_out, data_pins_oe;
  logic [LANES-1:0] parity_pins_in, parity_pins_out, parity_pins_oe;
  logic [WORD_W-1:0] mem_exp [4];
  logic [3:0] sel = 4'h2;
  logic [2:0] asy = 3'h1;
  int errors = 0;
  int checks_done = 0;
  wire [WORD_W-1:0] seen_word = {parity_pins_out, data_pins_out};
  wire [WORD_W-1:0] seen_oe = {parity_pins_oe, data_pins_oe};

  sram_pin_control dut (
    .core_clk, .reset_n, .address, .chip_select_first_low, .chip_select_mid_high,
    .chip_select_last_low, .package_is_bga, .cpu_addr_strobe_n, .ctrl_addr_strobe_n,
    .burst_advance_n, .lane_write_enable_n, .lane_select_n, .output_enable_n,
    .sleep_request, .burst_interleave_strap, .data_pins_in, .data_pins_out,
    .data_pins_oe, .parity_pins_in, .parity_pins_out, .parity_pins_oe
  );
  sram_host_model host (
    .core_clk, .drive_en, .drive_word, .sleep_on, .data_pins_out, .data_pins_oe,
    .parity_pins_out, .parity_pins_oe, .data_pins_in, .parity_pins_in, .sleep_request
  );

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [WORD_W-1:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // s = {cpu strobe, ctrl strobe, advance, lane write enable}, all active low
  task automatic step(input logic [3:0] s, ln, input logic [ADDR_W-1:0] a,
                      input logic [WORD_W-1:0] w);
    @(posedge core_clk);
    {cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, lane_write_enable_n} <= s;
    {package_is_bga, chip_select_first_low, chip_select_mid_high, chip_select_last_low} <= sel;
    {output_enable_n, sleep_on, burst_interleave_strap} <= asy;
    lane_select_n <= ln;
    address <= a;
    drive_en <= ~s[0];
    drive_word <= w;
    @(negedge core_clk);
  endtask

  task automatic t_write();
    for (int i = 0; i < 4; i++) begin
      mem_exp[i] = {4'(i), 12'hC3A, 20'h00100 + 20'(i)};
      step(4'hA, 4'h0, 20'h00100 + 20'(i), mem_exp[i]);
      if (i > 0) chk("oe in write", seen_oe, 36'h0);
    end
    step(4'hA, 4'hE, 20'h00101, ONES);
    mem_exp[1] = mem_exp[1] | 36'h1_0000_00FF;
    step(4'hB, 4'h0, 20'h00102, 36'h0);
    step(4'h2, 4'h0, 20'h00103, 36'h0);
    step(4'hF, 4'hF, 20'h0, 36'h0);
    $display("test write done");
  endtask

  task automatic t_read(input logic strap, input logic [1:0] start);
    logic [1:0] idx;
    asy = {2'h0, strap};
    sel = 4'h0;
    step(4'hB, 4'hF, 20'h0, 36'h0);
    sel = 4'h2;
    repeat (4) step(4'hF, 4'hF, 20'h0, 36'h0);
    step(4'h7, 4'hF, {18'h00040, start}, 36'h0);
    for (int k = 0; k < 4; k++) begin
      idx = strap ? (start ^ 2'(k)) : (start + 2'(k));
      sel = (k == 1) ? 4'h0 : 4'h2;
      step((k < 3) ? 4'hD : 4'hF, 4'hF, 20'h0, 36'h0);
      chk("burst beat", seen_word, mem_exp[idx]);
      chk("beat drive", seen_oe, (k == 0) ? 36'h0 : ONES);
    end
    sel = 4'h6;
    step(4'h7, 4'hF, 20'h00200, 36'h0);
    chk("held beat", seen_word, mem_exp[idx]);
    sel = 4'h2;
    step(4'hF, 4'hF, 20'h0, 36'h0);
    chk("strobe ignored", seen_word, mem_exp[idx]);
    $display("test read done");
  endtask

  // Processor-strobe load, then writes on the following beats of the burst
  task automatic t_burst_write();
    mem_exp[0] = 36'h5_A5A5_0F0F;
    mem_exp[1] = 36'hA_5A5A_F0F0;
    step(4'h7, 4'hF, 20'h00100, 36'h0);
    step(4'hC, 4'h0, 20'h0, mem_exp[0]);
    chk("oe in burst write", seen_oe, 36'h0);
    step(4'hE, 4'h0, 20'h0, mem_exp[1]);
    step(4'h7, 4'hF, 20'h00100, 36'h0);
    step(4'hD, 4'hF, 20'h0, 36'h0);
    chk("burst write beat 0", seen_word, mem_exp[0]);
    step(4'hF, 4'hF, 20'h0, 36'h0);
    chk("burst write beat 1", seen_word, mem_exp[1]);
    $display("test burst write done");
  endtask

  task automatic t_sel(input logic [3:0] s, input logic [WORD_W-1:0] exp);
    sel = s;
    step(4'h7, 4'hF, 20'h00100, 36'h0);
    repeat (2) step(4'hD, 4'hF, 20'h0, 36'h0);
    chk("select drive", seen_oe, exp);
    sel = 4'h2;
    $display("test select done");
  endtask

  task automatic t_async(input logic [2:0] a, input logic [WORD_W-1:0] exp);
    asy = a;
    repeat (6) step(4'hF, 4'hF, 20'h0, 36'h0);
    chk("async drive", seen_oe, exp);
    $display("test async done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Every scenario uses fixed step counts; this only catches a stuck run
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'h1;
    repeat (6) step(4'hF, 4'hF, 20'h0, 36'h0);
    t_write();
    t_read(1'h1, 2'h1);
    t_read(1'h0, 2'h3);
    t_burst_write();
    t_sel(4'h0, 36'h0);
    t_sel(4'h3, 36'h0);
    t_sel(4'hB, ONES);
    t_async(3'h5, 36'h0);
    t_async(3'h1, ONES);
    t_async(3'h3, 36'h0);
    final_report();
  end
endmodule
`default_nettype wire
